// ==== hdl/bmf_defs.svh ====
// Constants shared by both ends of the bus-matching FIFO link
`ifndef BMF_DEFS_SVH
`define BMF_DEFS_SVH

// ----------------------------------------
// Memory geometry
// ----------------------------------------
`define BMF_DEPTH 4096
`define BMF_PTR_W 13
`define BMF_OFS_W 12

// ----------------------------------------
// Default offsets, picked by the three select levels
// ----------------------------------------
`define BMF_DFLT_OFS_0 12'h007
`define BMF_DFLT_OFS_1 12'h00F
`define BMF_DFLT_OFS_2 12'h01F
`define BMF_DFLT_OFS_3 12'h03F
`define BMF_DFLT_OFS_4 12'h07F
`define BMF_DFLT_OFS_5 12'h0FF
`define BMF_DFLT_OFS_6 12'h1FF
`define BMF_DFLT_OFS_7 12'h3FF

// ----------------------------------------
// Timing
// ----------------------------------------
`define BMF_CLK_NS 4
`define BMF_LINK_HALF_NS 20
`define BMF_LINK_HALF_CYC ((`BMF_LINK_HALF_NS + `BMF_CLK_NS - 1) / `BMF_CLK_NS)

// ----------------------------------------
// Writer/reader end register map
// ----------------------------------------
`define BMF_REG_CONFIG 8'h00
`define BMF_REG_COMMAND 8'h04
`define BMF_REG_WDATA 8'h08
`define BMF_REG_RDATA 8'h0C
`define BMF_REG_STATUS 8'h10

// Command bits
`define BMF_CMD_WCLK 0
`define BMF_CMD_RCLK 1
`define BMF_CMD_SCLK 2
`define BMF_CMD_FULL_RST 3
`define BMF_CMD_PTR_RST 4

`endif

// ==== hdl/bmf_pkg.sv ====
// Types shared by both ends of the bus-matching FIFO link
`include "bmf_defs.svh"
package bmf_pkg;

	// ----------------------------------------
	// Pins from writer/reader to the device
	// ----------------------------------------
	typedef struct packed {
		logic write_port_clock;
		logic read_port_clock;
		logic serial_shift_clock;
		logic [17:0] data_in_bus;
		logic write_strobe_enable_n;
		logic read_strobe_enable_n;
		logic serial_load_enable_n;
		logic offset_load_n;
		logic fall_through_si;
		logic offset_select_0;
		logic offset_select_1;
		logic flag_timing_select;
		logic input_width_select;
		logic output_width_select;
		logic byte_order_select;
		logic parity_placement_select;
		logic full_reset_n;
		logic pointer_only_reset_n;
		logic mark;
		logic replay_request_n;
		logic read_select_n;
		logic output_drive_enable_n;
	} bmf_pin_s;

	// Configuration latched during full reset
	typedef struct packed {
		logic fall_through;
		logic flag_sync;
		logic in_x9;
		logic out_x9;
		logic little;
		logic interspersed;
		logic [2:0] dflt_sel;
	} bmf_cfg_s;

	// Writer/reader CONFIG register layout, bit 0 last
	typedef struct packed {
		logic drive;
		logic read_select;
		logic replay;
		logic mark;
		logic sel1;
		logic sel0;
		logic interspersed;
		logic little;
		logic out_x9;
		logic in_x9;
		logic flag_timing;
		logic fall_through;
		logic serial_bit;
		logic offset_load;
		logic serial_load;
		logic read_strobe;
		logic write_strobe;
	} bmf_host_cfg_s;

	typedef enum logic [1:0] {
		BMF_IDLE = 2'b00,
		BMF_SETUP = 2'b01,
		BMF_HIGH = 2'b11,
		BMF_LOW = 2'b10
	} bmf_seq_e;

	typedef logic [`BMF_PTR_W-1:0] bmf_ptr_t;
	typedef logic [`BMF_OFS_W-1:0] bmf_ofs_t;

endpackage

// ==== hdl/bmf_link_if.sv ====
// Link between the FIFO device and its writer/reader logic
`timescale 1ns/1ps
interface bmf_link_if;
	import bmf_pkg::*;

	bmf_pin_s to_dev;
	logic [17:0] data_out_bus;
	logic data_out_en;
	logic almost_empty_flag_n;
	logic almost_full_flag_n;
	logic power_down;

	modport dev (
		input to_dev,
		output data_out_bus, data_out_en, almost_empty_flag_n, almost_full_flag_n, power_down
	);

	modport host (
		output to_dev,
		input data_out_bus, data_out_en, almost_empty_flag_n, almost_full_flag_n, power_down
	);

endinterface

// ==== hdl/bmf_fifo_dev.sv ====
// Device end of the bus-matching FIFO: offsets, flags, pointers, sizing
//
// Function
// - Eight default offsets chosen at full reset
// - Empty and full thresholds counted from boundaries
// - Serial clock shifts one offset bit in
// - Write clock loads offsets from data input
// - Read clock shows offsets on data output
// - Full reset clears pointers, latches timing mode
// - Pointer reset keeps modes and offsets
// - Flags recomputed after pointer reset
// - Asynchronous flags set and clear on opposite clocks
// - Synchronous flags move on own clock only
// - Mark records current read location
// - Replay returns read pointer to mark
// - Width selects give four port size pairs
// - Big-endian reads most significant byte first
// - Little-endian reads least significant byte first
// - Interspersed parity drops D8 from offsets (only for x18 input here; x9 input keeps D8)
// - Non-interspersed uses D8, drops D16, D17
// - Idle means power-down, operations wake it about four cycles later, after the pin filter
// - Output driven only with both enables
// - Timing-mode pin becomes serial input afterward
// - Port widths sampled during full reset
// - Byte order low big, high little
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "bmf_defs.svh"
module bmf_fifo_dev (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Link to writer and reader
	bmf_link_if.dev LINK
);
	import bmf_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		bmf_pin_s s1;
		bmf_pin_s s2;
		bmf_pin_s s3;
		bmf_pin_s flt;
		bmf_cfg_s cfg;
		logic [`BMF_DEPTH-1:0][8:0] mem;
		bmf_ptr_t wr;
		bmf_ptr_t rd;
		bmf_ptr_t mark_ptr;
		bmf_ofs_t ae_ofs;
		bmf_ofs_t af_ofs;
		logic ofs_wsel;
		logic ofs_rsel;
		logic rcs_q;
		logic [17:0] dout;
		logic dout_en;
		logic ae_n;
		logic af_n;
		logic pdown;
	} bmf_dev_state_s;

	bmf_dev_state_s q;
	bmf_dev_state_s n;
	bmf_pin_s f;
	logic wev;
	logic rev;
	logic sev;
	logic ld;
	logic aec;
	logic afc;
	bmf_ptr_t cnt;
	bmf_ptr_t ncnt;
	bmf_ptr_t wneed;
	bmf_ptr_t rneed;
	bmf_ptr_t wr1;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic bmf_ofs_t dflt_ofs(input logic [2:0] sel);
		bmf_ofs_t v;
		v = `BMF_DFLT_OFS_0;
		unique case (sel)
			3'h0: v = `BMF_DFLT_OFS_0;
			3'h1: v = `BMF_DFLT_OFS_1;
			3'h2: v = `BMF_DFLT_OFS_2;
			3'h3: v = `BMF_DFLT_OFS_3;
			3'h4: v = `BMF_DFLT_OFS_4;
			3'h5: v = `BMF_DFLT_OFS_5;
			3'h6: v = `BMF_DFLT_OFS_6;
			3'h7: v = `BMF_DFLT_OFS_7;
		endcase
		return v;
	endfunction

	// Offset bits taken from a parallel write word
	function automatic bmf_ofs_t par_ofs(input logic [17:0] d, input bmf_cfg_s c);
		bmf_ofs_t v;
		if (c.in_x9) begin
			v = {3'h0, d[8:0]};
		end else if (c.interspersed) begin
			v = {d[12:9], d[7:0]};
		end else begin
			v = d[11:0];
		end
		return v;
	endfunction

	// Word at a read location, byte order per configuration
	function automatic logic [17:0] head_word(input bmf_ptr_t p);
		bmf_ptr_t p1;
		logic [17:0] w;
		p1 = p + bmf_ptr_t'(1);
		if (q.cfg.out_x9) begin
			w = {9'h000, q.mem[p[`BMF_PTR_W-2:0]]};
		end else if (q.cfg.little) begin
			w = {q.mem[p1[`BMF_PTR_W-2:0]], q.mem[p[`BMF_PTR_W-2:0]]};
		end else begin
			w = {q.mem[p[`BMF_PTR_W-2:0]], q.mem[p1[`BMF_PTR_W-2:0]]};
		end
		return w;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		// A pin level counts once the second and third stages agree
		f = (q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3));
		wev = f.write_port_clock & ~q.flt.write_port_clock;
		rev = f.read_port_clock & ~q.flt.read_port_clock;
		sev = f.serial_shift_clock & ~q.flt.serial_shift_clock;
		ld = ~f.offset_load_n;
		wneed = q.cfg.in_x9 ? bmf_ptr_t'(1) : bmf_ptr_t'(2);
		rneed = q.cfg.out_x9 ? bmf_ptr_t'(1) : bmf_ptr_t'(2);
		cnt = q.wr - q.rd;
		wr1 = q.wr + bmf_ptr_t'(1);
		n = q;
		n.s1 = LINK.to_dev;
		n.s2 = q.s1;
		n.s3 = q.s2;
		n.flt = f;
		if (!f.full_reset_n) begin
			// Straps captured every cycle of full reset, frozen after it
			n.cfg.fall_through = f.fall_through_si;
			n.cfg.flag_sync = f.flag_timing_select;
			n.cfg.in_x9 = f.input_width_select;
			n.cfg.out_x9 = f.output_width_select;
			n.cfg.little = f.byte_order_select;
			n.cfg.interspersed = f.parity_placement_select;
			n.cfg.dflt_sel = {f.offset_load_n, f.offset_select_1, f.offset_select_0};
			n.ae_ofs = dflt_ofs(n.cfg.dflt_sel);
			n.af_ofs = dflt_ofs(n.cfg.dflt_sel);
			n.wr = '0;
			n.rd = '0;
			n.mark_ptr = '0;
			n.ofs_wsel = 1'b0;
			n.ofs_rsel = 1'b0;
			n.dout = '0;
		end else if (!f.pointer_only_reset_n) begin
			// Modes and offsets stay as they are
			n.wr = '0;
			n.rd = '0;
			n.mark_ptr = '0;
		end else begin
			if (wev && !f.write_strobe_enable_n) begin
				if (ld) begin
					// Alternate: almost-empty offset first, then almost-full
					if (q.ofs_wsel) begin
						n.af_ofs = par_ofs(f.data_in_bus, q.cfg);
					end else begin
						n.ae_ofs = par_ofs(f.data_in_bus, q.cfg);
					end
					n.ofs_wsel = ~q.ofs_wsel;
				end else if (cnt + wneed <= bmf_ptr_t'(`BMF_DEPTH)) begin
					// Memory holds bytes in stream order; writes into a full FIFO are dropped
					if (q.cfg.in_x9) begin
						n.mem[q.wr[`BMF_PTR_W-2:0]] = f.data_in_bus[8:0];
					end else if (q.cfg.little) begin
						n.mem[q.wr[`BMF_PTR_W-2:0]] = f.data_in_bus[8:0];
						n.mem[wr1[`BMF_PTR_W-2:0]] = f.data_in_bus[17:9];
					end else begin
						n.mem[q.wr[`BMF_PTR_W-2:0]] = f.data_in_bus[17:9];
						n.mem[wr1[`BMF_PTR_W-2:0]] = f.data_in_bus[8:0];
					end
					n.wr = q.wr + wneed;
				end
			end
			if (sev && !f.serial_load_enable_n && ld) begin
				// Shared pin serves as serial input outside full reset
				{n.ae_ofs, n.af_ofs} = {q.ae_ofs[`BMF_OFS_W-2:0], q.af_ofs, f.fall_through_si};
			end
			if (rev) begin
				n.rcs_q = ~f.read_select_n;
				if (f.mark) begin
					n.mark_ptr = q.rd;
				end
				if (!f.replay_request_n) begin
					n.rd = q.mark_ptr;
				end else if (!f.read_strobe_enable_n) begin
					if (ld) begin
						n.dout = {6'h00, q.ofs_rsel ? q.af_ofs : q.ae_ofs};
						n.ofs_rsel = ~q.ofs_rsel;
					end else if (cnt >= rneed) begin
						if (!q.cfg.fall_through) begin
							n.dout = head_word(q.rd);
						end
						n.rd = q.rd + rneed;
					end
				end
			end
			// Fall-through keeps the head word on the output without a read
			if (q.cfg.fall_through && !ld && (n.wr - n.rd >= rneed)) begin
				n.dout = head_word(n.rd);
			end
		end
		// Flags follow the occupancy after this cycle's updates
		ncnt = n.wr - n.rd;
		aec = ncnt <= {1'b0, n.ae_ofs};
		afc = ncnt >= bmf_ptr_t'(`BMF_DEPTH) - {1'b0, n.af_ofs};
		if (!f.full_reset_n || !f.pointer_only_reset_n) begin
			n.ae_n = ~aec;
			n.af_n = ~afc;
		end else if (q.cfg.flag_sync) begin
			if (rev) begin
				n.ae_n = ~aec;
			end
			if (wev) begin
				n.af_n = ~afc;
			end
		end else begin
			if (rev && aec) begin
				n.ae_n = 1'b0;
			end else if (wev && !aec) begin
				n.ae_n = 1'b1;
			end
			if (wev && afc) begin
				n.af_n = 1'b0;
			end else if (rev && !afc) begin
				n.af_n = 1'b1;
			end
		end
		// Enable path goes through the pin filter, so it is not instant
		n.dout_en = ~f.output_drive_enable_n & n.rcs_q;
		n.pdown = f.write_strobe_enable_n & f.read_strobe_enable_n & f.serial_load_enable_n
			& f.offset_load_n & f.full_reset_n & f.pointer_only_reset_n & ~f.mark
			& f.replay_request_n;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (RESET) begin
			q <= '0;
			q.af_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign LINK.data_out_bus = q.dout;
	assign LINK.data_out_en = q.dout_en;
	assign LINK.almost_empty_flag_n = q.ae_n;
	assign LINK.almost_full_flag_n = q.af_n;
	assign LINK.power_down = q.pdown;

endmodule

// ==== hdl/bmf_fifo_host.sv ====
// Writer/reader end: register port that drives the FIFO device pins
`timescale 1ns/1ps
`include "bmf_defs.svh"
module bmf_fifo_host (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// Link to the FIFO device
	bmf_link_if.host LINK
);
	import bmf_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		bmf_host_cfg_s cfg;
		logic [17:0] wdata;
		logic [17:0] rdata;
		logic [4:0] mask;
		bmf_seq_e state;
		logic [7:0] cnt;
		logic [31:0] bus_rd;
		bmf_pin_s pins;
	} bmf_host_state_s;

	localparam logic [7:0] HALF = 8'(`BMF_LINK_HALF_CYC);

	bmf_host_state_s q;
	bmf_host_state_s n;
	logic full_rst;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = q;
		n.bus_rd = '0;
		// Each phase of a link clock pulse lasts HALF cycles
		unique case (q.state)
			BMF_IDLE: begin
			end
			BMF_SETUP: begin
				n.cnt = q.cnt - 8'h01;
				if (q.cnt == 8'h01) begin
					n.state = BMF_HIGH;
					n.cnt = HALF;
				end
			end
			BMF_HIGH: begin
				n.cnt = q.cnt - 8'h01;
				if (q.cnt == 8'h01) begin
					n.state = BMF_LOW;
					n.cnt = HALF;
				end
			end
			BMF_LOW: begin
				n.cnt = q.cnt - 8'h01;
				if (q.cnt == 8'h01) begin
					n.state = BMF_IDLE;
					n.mask = '0;
					if (q.mask[`BMF_CMD_RCLK]) begin
						n.rdata = LINK.data_out_bus;
					end
				end
			end
		endcase
		if (WR) begin
			case (ADDR)
				`BMF_REG_CONFIG: n.cfg = WDATA[$bits(bmf_host_cfg_s)-1:0];
				`BMF_REG_WDATA: n.wdata = WDATA[17:0];
				`BMF_REG_COMMAND: begin
					// Commands while busy are dropped
					if (q.state == BMF_IDLE && WDATA[4:0] != 5'h00) begin
						n.mask = WDATA[4:0];
						n.state = BMF_SETUP;
						n.cnt = HALF;
					end
				end
				default: begin
				end
			endcase
		end
		if (RD) begin
			case (ADDR)
				`BMF_REG_CONFIG: n.bus_rd = 32'(q.cfg);
				`BMF_REG_WDATA: n.bus_rd = 32'(q.wdata);
				`BMF_REG_RDATA: n.bus_rd = 32'(q.rdata);
				`BMF_REG_STATUS: n.bus_rd = 32'({LINK.power_down, LINK.almost_full_flag_n,
					LINK.almost_empty_flag_n, LINK.data_out_en, q.state != BMF_IDLE});
				default: n.bus_rd = '0;
			endcase
		end
		// Pins follow the registers one cycle later
		full_rst = (q.state != BMF_IDLE) && q.mask[`BMF_CMD_FULL_RST];
		n.pins.write_port_clock = (q.state == BMF_HIGH) && q.mask[`BMF_CMD_WCLK];
		n.pins.read_port_clock = (q.state == BMF_HIGH) && q.mask[`BMF_CMD_RCLK];
		n.pins.serial_shift_clock = (q.state == BMF_HIGH) && q.mask[`BMF_CMD_SCLK];
		n.pins.data_in_bus = q.wdata;
		n.pins.write_strobe_enable_n = ~q.cfg.write_strobe;
		n.pins.read_strobe_enable_n = ~q.cfg.read_strobe;
		n.pins.serial_load_enable_n = ~q.cfg.serial_load;
		n.pins.offset_load_n = ~q.cfg.offset_load;
		n.pins.fall_through_si = full_rst ? q.cfg.fall_through : q.cfg.serial_bit;
		n.pins.offset_select_0 = q.cfg.sel0;
		n.pins.offset_select_1 = q.cfg.sel1;
		n.pins.flag_timing_select = q.cfg.flag_timing;
		n.pins.input_width_select = q.cfg.in_x9;
		n.pins.output_width_select = q.cfg.out_x9;
		n.pins.byte_order_select = q.cfg.little;
		n.pins.parity_placement_select = q.cfg.interspersed;
		n.pins.full_reset_n = ~full_rst;
		n.pins.pointer_only_reset_n = ~((q.state != BMF_IDLE) && q.mask[`BMF_CMD_PTR_RST]);
		n.pins.mark = q.cfg.mark;
		n.pins.replay_request_n = ~q.cfg.replay;
		n.pins.read_select_n = ~q.cfg.read_select;
		n.pins.output_drive_enable_n = ~q.cfg.drive;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (RESET) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign RDATA = q.bus_rd;
	assign LINK.to_dev = q.pins;

endmodule

// ==== tb/bmf_link_sva.sv ====
// Checker for the link between the FIFO device and its writer/reader end
`timescale 1ns/1ps
module bmf_link_sva (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Link signals
	input wire bmf_pkg::bmf_pin_s to_dev,
	input wire logic [17:0] data_out_bus,
	input wire logic data_out_en,
	input wire logic almost_empty_flag_n,
	input wire logic almost_full_flag_n,
	input wire logic power_down
);
	import bmf_pkg::*;

	// ----------------------------------------
	// Cycles since each port clock or reset was last active
	// ----------------------------------------
	// Pin filter adds about four cycles, so a flag move must follow its clock within eight
	logic [3:0] wr_age;
	logic [3:0] rd_age;
	logic [3:0] rst_age;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			wr_age <= 4'hF;
			rd_age <= 4'hF;
			rst_age <= 4'h0;
		end else begin
			wr_age <= to_dev.write_port_clock ? 4'h0 : wr_age + {3'h0, wr_age != 4'hF};
			rd_age <= to_dev.read_port_clock ? 4'h0 : rd_age + {3'h0, rd_age != 4'hF};
			rst_age <= (!to_dev.full_reset_n || !to_dev.pointer_only_reset_n) ? 4'h0 :
				rst_age + {3'h0, rst_age != 4'hF};
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	chk_wclk_pulse: assert property ($rose(to_dev.write_port_clock) |-> to_dev.write_port_clock [*5] ##1 !to_dev.write_port_clock)
		else $error("write clock pulse has wrong width");
	chk_rclk_pulse: assert property ($rose(to_dev.read_port_clock) |-> to_dev.read_port_clock [*5] ##1 !to_dev.read_port_clock)
		else $error("read clock pulse has wrong width");
	chk_sclk_pulse: assert property ($rose(to_dev.serial_shift_clock) |-> to_dev.serial_shift_clock [*5] ##1 !to_dev.serial_shift_clock)
		else $error("serial clock pulse has wrong width");
	chk_full_hold: assert property ($fell(to_dev.full_reset_n) |-> !to_dev.full_reset_n [*8])
		else $error("full reset pulse too short");
	chk_full_flags: assert property (!to_dev.full_reset_n [*8] |=> !almost_empty_flag_n && almost_full_flag_n)
		else $error("flags wrong during full reset");
	chk_part_flags: assert property (!to_dev.pointer_only_reset_n [*8] |=> !almost_empty_flag_n && almost_full_flag_n)
		else $error("flags wrong during pointer reset");
	chk_af_by_write: assert property ($fell(almost_full_flag_n) |-> wr_age < 4'h8)
		else $error("almost full asserted without a write clock");
	chk_ae_by_read: assert property ($fell(almost_empty_flag_n) |-> rd_age < 4'h8 || rst_age < 4'h8)
		else $error("almost empty asserted without a read clock");
	chk_out_off: assert property (to_dev.output_drive_enable_n [*8] |=> !data_out_en)
		else $error("output driven while drive enable is off");
	chk_wake_write: assert property ($rose(to_dev.write_port_clock) && !to_dev.write_strobe_enable_n |-> ##[1:8] !power_down)
		else $error("device stayed powered down during a write");
endmodule

// ==== tb/bmf_fifo_tb.sv ====
// Testbench driving both FIFO ends through the writer/reader register port
`timescale 1ns/1ps
`include "bmf_defs.svh"
module bmf_fifo_tb;
	import bmf_pkg::*;

	// CONFIG bit masks
	localparam logic [31:0] WS = 32'h1, SL = 32'h4, OL = 32'h8, SB = 32'h10, FM = 32'h40, IX = 32'h80;
	localparam logic [31:0] OX = 32'h100, LE = 32'h200, IP = 32'h400, S0 = 32'h800, S1 = 32'h1000;
	localparam logic [31:0] MK = 32'h2000, RP = 32'h4000, RDC = 32'h18002, FT = 32'h20;
	localparam bmf_ofs_t DFLT [8] = '{`BMF_DFLT_OFS_0, `BMF_DFLT_OFS_1, `BMF_DFLT_OFS_2, `BMF_DFLT_OFS_3,
		`BMF_DFLT_OFS_4, `BMF_DFLT_OFS_5, `BMF_DFLT_OFS_6, `BMF_DFLT_OFS_7};
	localparam logic [23:0] SER = 24'h0011C6;

	logic clk;
	logic reset;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr_s;
	logic rd_s;
	logic [31:0] rdata;
	int n_errors = 0;
	int check_count = 0;

	bmf_link_if link ();
	bmf_fifo_dev bmf_fifo_dev_inst (.CLK(clk), .RESET(reset), .LINK(link));
	bmf_fifo_host bmf_fifo_host_inst (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
		.RD(rd_s), .RDATA(rdata), .LINK(link));
	bmf_link_sva bmf_link_sva_inst (.CLK(clk), .RESET(reset), .to_dev(link.to_dev),
		.data_out_bus(link.data_out_bus), .data_out_en(link.data_out_en),
		.almost_empty_flag_n(link.almost_empty_flag_n), .almost_full_flag_n(link.almost_full_flag_n),
		.power_down(link.power_down));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ----------------------------------------
	// Register port tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h expected=%h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Commands are refused while busy, so every one waits for busy to drop
	task automatic cmd(input logic [31:0] c);
		logic [31:0] s;
		wr(`BMF_REG_COMMAND, c);
		s = 32'h1;
		for (int i = 0; i < 40 && s[0] !== 1'b0; i++) begin
			rd(`BMF_REG_STATUS, s);
		end
		if (s[0] !== 1'b0) begin
			n_errors++;
			stop_test();
		end
	endtask

	// Flags pass the pin filter, so status is polled under a bound
	task automatic expect_st(input logic [31:0] m, input logic [31:0] v);
		logic [31:0] s;
		for (int i = 0; i < 30; i++) begin
			rd(`BMF_REG_STATUS, s);
			if ((s & m) === v) break;
		end
		check(s & m, v);
	endtask

	task automatic freset(input logic [31:0] c);
		wr(`BMF_REG_CONFIG, c);
		cmd(32'h8);
	endtask

	task automatic push(input logic [31:0] c, input logic [31:0] d);
		wr(`BMF_REG_CONFIG, c);
		wr(`BMF_REG_WDATA, d);
		cmd(32'h1);
	endtask

	task automatic pop_chk(input logic [31:0] c, input logic [31:0] e);
		logic [31:0] d;
		wr(`BMF_REG_CONFIG, c);
		cmd(32'h2);
		rd(`BMF_REG_RDATA, d);
		check(d, e);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		reset = 1'b1;
		addr = 8'h00;
		wdata = 32'h0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rd(`BMF_REG_STATUS, d);
		check(d & 32'hC, 32'h8);
		for (int i = 0; i < 8; i++) begin
			freset((i[0] ? S0 : 32'h0) | (i[1] ? S1 : 32'h0) | (i[2] ? 32'h0 : OL));
			expect_st(32'hC, 32'h8);
			pop_chk(OL | RDC, {20'h0, DFLT[i]});
			pop_chk(OL | RDC, {20'h0, DFLT[i]});
		end
		for (int k = 0; k < 4; k++) begin
			freset((k[0] ? LE : 32'h0) | (k[1] ? IX : OX));
			if (k[1]) begin
				push(WS, 32'h123);
				push(WS, 32'h045);
				pop_chk(RDC, k[0] ? 32'h08B23 : 32'h24645);
			end else begin
				push(WS, 32'h24645);
				pop_chk(RDC, k[0] ? 32'h045 : 32'h123);
				pop_chk(RDC, k[0] ? 32'h123 : 32'h045);
			end
			expect_st(32'h2, 32'h2);
		end
		wr(`BMF_REG_CONFIG, RDC & ~32'h10000);
		expect_st(32'h2, 32'h0);
		for (int k = 0; k < 2; k++) begin
			freset(k[0] ? IP : 32'h0);
			push(OL | WS, 32'h30F55);
			push(OL | WS, 32'h00ABC);
			pop_chk(OL | RDC, k[0] ? 32'h755 : 32'hF55);
			pop_chk(OL | RDC, k[0] ? 32'h5BC : 32'hABC);
		end
		freset(32'h0);
		for (int i = 23; i >= 0; i--) begin
			wr(`BMF_REG_CONFIG, SL | OL | (SER[i] ? SB : 32'h0));
			cmd(32'h4);
		end
		push(WS, 32'h0AA);
		expect_st(32'h4, 32'h4);
		cmd(32'h10);
		expect_st(32'hC, 32'h8);
		pop_chk(OL | RDC, 32'h001);
		pop_chk(OL | RDC, 32'h1C6);
		for (int k = 0; k < 2; k++) begin
			freset(OL | IX | OX | (k[0] ? FM : 32'h0));
			for (int i = 0; i < 9; i++) begin
				push(WS, i);
			end
			expect_st(32'h4, k[0] ? 32'h0 : 32'h4);
			pop_chk(RDC, 32'h0);
			expect_st(32'h4, 32'h4);
			pop_chk(RDC, 32'h1);
			expect_st(32'h4, 32'h0);
		end
		// Fall-through: head shows without a read strobe
		freset(IX | OX | FT);
		push(WS, 32'h05A);
		push(WS, 32'h06B);
		pop_chk(32'h0, 32'h05A);
		pop_chk(RDC, 32'h06B);
		// Widest almost-full offset, so one word trips the flag
		freset(32'h0);
		push(OL | WS, 32'h00000);
		push(OL | WS, 32'h00FFF);
		push(WS, 32'h24645);
		expect_st(32'h18, 32'h0);
		pop_chk(RDC, 32'h24645);
		expect_st(32'h8, 32'h8);
		freset(IX | OX);
		for (int i = 1; i < 4; i++) begin
			push(WS, i * 32'h11);
		end
		pop_chk(RDC | MK, 32'h11);
		pop_chk(RDC, 32'h22);
		wr(`BMF_REG_CONFIG, RP);
		cmd(32'h2);
		pop_chk(RDC, 32'h11);
		wr(`BMF_REG_CONFIG, 32'h0);
		expect_st(32'h10, 32'h10);
		stop_test();
	end
endmodule
